// ---- verilog/dcc_pkg.sv ----
// Package for the dual comparator control block: register map, fields, resets, types.
// Assumes an 8-bit register file reached over a 32-bit Avalon-MM slave.
package dcc_pkg;
    // Register indices as printed; byte address is four times the index
    localparam logic [7:0] DCC_IDX_INTERRUPT_CONTROL      = 8'h0b;
    localparam logic [7:0] DCC_IDX_PERIPHERAL_IRQ_FLAGS   = 8'h0c;
    localparam logic [7:0] DCC_IDX_COMPARATOR_CONTROL     = 8'h1f;
    localparam logic [7:0] DCC_IDX_PORT_A_DIRECTION       = 8'h85;
    localparam logic [7:0] DCC_IDX_PERIPHERAL_IRQ_ENABLES = 8'h8c;
    localparam logic [7:0] DCC_IDX_REFERENCE_LADDER       = 8'h9f;
    localparam logic [7:0] DCC_IDX_PORT_A_DATA            = 8'h05;
    localparam int         DCC_ADDR_W                     = 10;

    // Reset values
    localparam logic [7:0] DCC_RST_INTERRUPT_CONTROL = 8'h00;
    localparam logic [7:0] DCC_RST_FLAGS  = 8'h00;
    localparam logic [7:0] DCC_RST_CMCTL  = 8'h00;
    localparam logic [4:0] DCC_RST_DIR    = 5'h1f;
    localparam logic [7:0] DCC_RST_ENABLE = 8'h00;
    localparam logic [7:0] DCC_RST_LADDER = 8'h00;

    // Field positions and masks
    localparam int         DCC_BIT_CHANGE      = 6;
    localparam int         DCC_BIT_GIE         = 7;
    localparam int         DCC_BIT_PERIPHERAL_IRQ_ENABLE        = 6;
    localparam int         DCC_BIT_SWITCH      = 3;
    localparam logic [7:0] DCC_CMCTL_WMASK     = 8'h0f;
    localparam logic [7:0] DCC_FLAGS_MASK      = 8'h40;
    localparam logic [7:0] DCC_LADDER_MASK     = 8'hef;
    localparam logic [7:0] DCC_DATA_MASK       = 8'h1f;

    // Comparator modes
    localparam logic [2:0] DCC_MODE_RESET    = 3'h0;
    localparam logic [2:0] DCC_MODE_SWITCHED = 3'h1;
    localparam logic [2:0] DCC_MODE_INTREF   = 3'h2;
    localparam logic [2:0] DCC_MODE_PINOUT   = 3'h6;
    localparam logic [2:0] DCC_MODE_OFF      = 3'h7;

    // Inverting-input sources presented to the analog side
    typedef enum logic [1:0] {DCC_SRC_PIN_ZERO, DCC_SRC_PIN_THREE, DCC_SRC_PIN_TWO, DCC_SRC_BUS_RX} dcc_src_e;

    // Analog steering bundle
    typedef struct packed {
        logic       cmp_power;
        logic       intref_to_noninv;
        dcc_src_e   one_inv_src;
        dcc_src_e   two_inv_src;
    } dcc_analog_s;

    // Port pin bundle
    typedef struct packed {
        logic [4:0] out;
        logic [4:0] oe;
        logic [4:0] analog;
    } dcc_pins_s;
endpackage

// ---- verilog/dcc_top.sv ----
// Digital control of two analog comparators: mode, routing, results, change flag, IRQ.
// Assumes comparator results arrive asynchronously and an Avalon-MM master with waitrequest.
// What the document requires of this block and its software
// R1 - Result bit high when non-inverting exceeds inverting
// R2 - Mode 010 routes internal reference to non-inverting
// R3 - Result bits readable, writes to them ignored
// R4 - Mode 110 puts raw results on pins three, four
// R5 - Direction bits still gate those pin drivers
// R6 - Port data reads zero on analog pins
// R7 - Result differing from reference sets change flag
// R8 - Flag bit 6; software writes clear or set
// R9 - Interrupt needs three enables; flag sets regardless
// R10 - Change during control read may be missed
// R11 - Control register access recaptures reference values
// R12 - Persistent mismatch keeps setting flag every cycle
// R13 - Comparators run in sleep; change wakes device
// R14 - Mode 111 powers both comparators off
// R15 - Wake from sleep keeps control register intact
// R16 - Reset loads mode 000, comparators powered down; here they are down only while reset is high, mode 000 powers them
// R17 - Unimplemented bits read zero, ignore writes
// R18 - Software waits response time before using results
// R19 - Software init order before enabling interrupts
// R20 - Switch bit picks inverting source in modes 001/010
// R21 - Software disables interrupts across mode change
// R22 - Results synchronised two stages before comparison
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
module dcc_top
    import dcc_pkg::*;
(
    input  wire logic                      core_clk,      // 100 MHz core clock
    input  wire logic                      reset,         // Synchronous reset, active high
    input  wire logic                      clk_en,        // Freezes all state when low
    input  wire logic [DCC_ADDR_W-1:0]     avs_address,   // Byte address
    input  wire logic                      avs_read,      // Read request
    input  wire logic                      avs_write,     // Write request
    input  wire logic [31:0]               avs_writedata, // Write data
    input  wire logic [3:0]                avs_byteenable,// Byte enables
    output logic      [31:0]               avs_readdata,  // Read data
    output logic                           avs_waitrequest, // Stall
    input  wire logic [1:0]                cmp_raw,       // Async comparator results
    input  wire logic [4:0]                port_pin_in,   // Async port pin levels
    input  wire logic                      sleep_active,  // Device in sleep
    output logic      [4:0]                port_pin_out,  // Pin output levels
    output logic      [4:0]                port_pin_oe,   // Pin output enables
    output dcc_pkg::dcc_analog_s           analog_ctl,    // Analog steering
    output logic      [7:0]                ladder_ctl,    // Reference ladder setting
    output logic                           irq_req,       // Interrupt request
    output logic                           wake_req       // Wake from sleep
);
    import dcc_pkg::*;

    // Whole block state
    typedef struct packed {
        logic [1:0]  sync1;
        logic [1:0]  sync2;
        logic [4:0]  psync1;
        logic [4:0]  psync2;
        logic [1:0]  ref_val;
        logic [7:0]  interrupt_control;
        logic        change_flag;
        logic        change_en;
        logic [3:0]  cmctl;
        logic [4:0]  dir;
        logic [7:0]  ladder;
        logic        ack;
        logic [31:0] rdata;
        logic [4:0]  pout;
        logic [4:0]  poe;
        dcc_analog_s analog;
        logic        irq;
        logic        wake;
        logic        rd_pending;
    } dcc_state_s;

    dcc_state_s st_r;
    dcc_state_s st_nxt;

    logic [7:0]             idx;
    logic                   acc;
    logic                   wr_go;
    logic                   rd_go;
    logic [7:0]             wbyte;
    logic [2:0]             mode;
    logic                   mismatch;
    logic [4:0]             analog_pins;

    // Decode, one-wait-state slave
    assign idx   = avs_address[DCC_ADDR_W-1:2];
    assign acc   = (avs_read || avs_write) && !st_r.ack;
    assign wr_go = acc && avs_write && avs_byteenable[0];
    assign rd_go = acc && avs_read;
    assign wbyte = avs_writedata[7:0];
    assign mode  = st_r.cmctl[2:0];

    // Pins consumed as analog inputs per mode
    always_comb begin
        unique case (mode)
            3'h0, 3'h1, 3'h2: analog_pins = 5'h0f;
            3'h3, 3'h4, 3'h6: analog_pins = 5'h07;
            3'h5:             analog_pins = 5'h06;
            default:          analog_pins = 5'h00;
        endcase
    end

    // Reference compare against synchronised results
    assign mismatch = (st_r.sync2 != st_r.ref_val);                           // R7 R22

    // Next state
    always_comb begin
        st_nxt        = st_r;
        st_nxt.sync1  = cmp_raw;
        st_nxt.sync2  = st_r.sync1;                                           // R22
        st_nxt.psync1 = port_pin_in;
        st_nxt.psync2 = st_r.psync1;
        st_nxt.ack    = acc;
        st_nxt.rd_pending = 1'b0;
        // Flag: software write first, then hardware set wins
        if (wr_go && idx == DCC_IDX_PERIPHERAL_IRQ_FLAGS) begin
            st_nxt.change_flag = wbyte[DCC_BIT_CHANGE];                       // R8
        end
        if (mismatch && !st_r.rd_pending) begin
            st_nxt.change_flag = 1'b1;                                        // R7 R12 R10
        end
        // Any access to the control register recaptures reference
        if (acc && idx == DCC_IDX_COMPARATOR_CONTROL) begin
            st_nxt.ref_val    = st_r.sync2;                                   // R11
            st_nxt.rd_pending = avs_read;                                     // R10
        end
        if (wr_go) begin
            unique case (idx)
                DCC_IDX_INTERRUPT_CONTROL:      st_nxt.interrupt_control = wbyte;
                DCC_IDX_COMPARATOR_CONTROL:     st_nxt.cmctl = wbyte[3:0];    // R3 R17
                DCC_IDX_PORT_A_DIRECTION:       st_nxt.dir = wbyte[4:0];      // R17
                DCC_IDX_PERIPHERAL_IRQ_ENABLES: st_nxt.change_en = wbyte[DCC_BIT_CHANGE]; // R17
                DCC_IDX_REFERENCE_LADDER:       st_nxt.ladder = wbyte & DCC_LADDER_MASK;
                default: ;
            endcase
        end
        // Read mux; unmapped reads zero
        st_nxt.rdata = 32'h0;
        if (rd_go) begin
            unique case (idx)
                DCC_IDX_INTERRUPT_CONTROL:      st_nxt.rdata[7:0] = st_r.interrupt_control;
                DCC_IDX_PERIPHERAL_IRQ_FLAGS:   st_nxt.rdata[7:0] = {1'b0, st_r.change_flag, 6'h00};
                DCC_IDX_COMPARATOR_CONTROL:     st_nxt.rdata[7:0] = {st_r.sync2[1], st_r.sync2[0],
                                                                     2'b00, st_r.cmctl}; // R1 R3 R17
                DCC_IDX_PORT_A_DIRECTION:       st_nxt.rdata[7:0] = {3'h0, st_r.dir};
                DCC_IDX_PERIPHERAL_IRQ_ENABLES: st_nxt.rdata[7:0] = {1'b0, st_r.change_en, 6'h00};
                DCC_IDX_REFERENCE_LADDER:       st_nxt.rdata[7:0] = st_r.ladder;
                DCC_IDX_PORT_A_DATA:            st_nxt.rdata[7:0] = {3'h0, st_r.psync2 & ~analog_pins}; // R6
                default:                        st_nxt.rdata = 32'h0;
            endcase
        end
        // Pin drivers: comparator results on pins three, four in mode 110
        st_nxt.poe = ~st_r.dir & ~analog_pins;                                // R5
        st_nxt.pout = 5'h00;
        if (mode == DCC_MODE_PINOUT) begin
            st_nxt.pout[3] = cmp_raw[0];                                      // R4
            st_nxt.pout[4] = cmp_raw[1];                                      // R4
        end
        // Analog steering
        st_nxt.analog.cmp_power        = !reset && mode != DCC_MODE_OFF;       // R14 R16 R13
        st_nxt.analog.intref_to_noninv = (mode == DCC_MODE_INTREF);           // R2
        st_nxt.analog.one_inv_src      = st_r.cmctl[DCC_BIT_SWITCH] ? DCC_SRC_PIN_THREE : DCC_SRC_PIN_ZERO; // R20
        st_nxt.analog.two_inv_src      = (mode == DCC_MODE_INTREF && !st_r.cmctl[DCC_BIT_SWITCH]) ?
                                         DCC_SRC_BUS_RX : DCC_SRC_PIN_TWO;    // R20
        // Interrupt and wake
        st_nxt.irq  = st_r.change_flag && st_r.change_en && st_r.interrupt_control[DCC_BIT_PERIPHERAL_IRQ_ENABLE]
                      && st_r.interrupt_control[DCC_BIT_GIE];                             // R9
        st_nxt.wake = sleep_active && st_r.change_flag && st_r.change_en;      // R13 R15
    end

    // State register with clock enable and synchronous reset
    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_r        <= '0;
            st_r.interrupt_control <= DCC_RST_INTERRUPT_CONTROL;
            st_r.cmctl  <= DCC_RST_CMCTL[3:0];                                 // R16
            st_r.dir    <= DCC_RST_DIR;
            st_r.ladder <= DCC_RST_LADDER;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from state
    assign avs_readdata    = st_r.rdata;
    assign avs_waitrequest = !st_r.ack;
    assign port_pin_out    = st_r.pout;
    assign port_pin_oe     = st_r.poe;
    assign analog_ctl      = st_r.analog;
    assign ladder_ctl      = st_r.ladder;
    assign irq_req         = st_r.irq;
    assign wake_req        = st_r.wake;
endmodule // dcc_top

// ---- verification/dcc_checker.sv ----
// Checker for dcc_top: bus handshake, readback masks, pin routing, reset state.
// Assumes it is bound into dcc_top, one clock, synchronous active-high reset.
`timescale 1ns/1ps
module dcc_checker
    import dcc_pkg::*;
(
    input wire logic                  core_clk,        // Core clock
    input wire logic                  reset,           // Synchronous reset
    input wire logic                  clk_en,          // Clock enable
    input wire logic [DCC_ADDR_W-1:0] avs_address,     // Byte address
    input wire logic                  avs_read,        // Read request
    input wire logic                  avs_write,       // Write request
    input wire logic [31:0]           avs_readdata,    // Read data
    input wire logic                  avs_waitrequest, // Stall
    input wire logic [1:0]            cmp_raw,         // Raw results
    input wire logic [4:0]            port_pin_out,    // Pin levels
    input wire dcc_analog_s           analog_ctl,      // Analog steering
    input wire logic                  irq_req,         // Interrupt request
    input wire logic                  wake_req         // Wake request
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // Read completion seen by the master
    wire logic rd_done = avs_read && !avs_waitrequest;

    a_wait_after_take: assert property ((avs_read || avs_write) && avs_waitrequest && clk_en |=> !avs_waitrequest)
        else $error("no answer after a taken request");
    a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer stood longer than one cycle");
    a_rdata_upper_zero: assert property (rd_done |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_ctl_unused_zero: assert property (rd_done && avs_address == 10'h07c |-> avs_readdata[5:4] == 2'h0)
        else $error("control unused bits not zero");
    a_flag_only_bit: assert property (rd_done && avs_address == 10'h030 |-> (avs_readdata[7:0] & 8'hbf) == 8'h0)
        else $error("flag register shows other bits");
    a_pin_low_zero: assert property (port_pin_out[2:0] == 3'h0)
        else $error("low pins driven by comparator path");
    a_pin_raw_path: assert property ((port_pin_out[4:3] & ~$past(cmp_raw)) == 2'h0)
        else $error("pin high without matching result");
    a_reset_quiet: assert property ($past(reset) |-> !analog_ctl.cmp_power && !irq_req && !wake_req)
        else $error("outputs active after reset");
    // Main scenarios
    cover property (rd_done && avs_address == 10'h07c);
    cover property (irq_req);
    cover property (port_pin_out[3]);
endmodule // dcc_checker

bind dcc_top dcc_checker dcc_checker_i (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cmp_raw(cmp_raw), .port_pin_out(port_pin_out),
    .analog_ctl(analog_ctl), .irq_req(irq_req), .wake_req(wake_req));

// ---- verification/testbench.sv ----
// Self-checking bench for dcc_top driven over its Avalon-MM slave port.
// Assumes one 100 MHz clock and the one-wait-state answer of the slave.
`timescale 1ns/1ps
module testbench;
    import dcc_pkg::*;
    localparam logic [7:0] CTL = DCC_IDX_COMPARATOR_CONTROL;
    localparam logic [7:0] FLG = DCC_IDX_PERIPHERAL_IRQ_FLAGS;
    localparam logic [7:0] DIR = DCC_IDX_PORT_A_DIRECTION;
    logic                  core_clk, reset, avs_read, avs_write, avs_waitrequest, sleep_active, irq_req, wake_req;
    logic [DCC_ADDR_W-1:0] avs_address;
    logic [31:0]           avs_writedata, avs_readdata;
    logic [1:0]            cmp_raw;
    logic [4:0]            port_pin_in, port_pin_out, port_pin_oe;
    logic [7:0]            ladder_ctl, rd;
    dcc_analog_s           analog_ctl;
    int                    n_fail, n_tests;
    logic [7:0]            regs [7] = '{8'h0b, 8'h0c, 8'h1f, 8'h85, 8'h8c, 8'h9f, 8'h40};
    logic [7:0]            rv [7] = '{8'h00, 8'h00, 8'h00, 8'h1f, 8'h00, 8'h00, 8'h00};
    logic [7:0]            wv [7] = '{8'hff, 8'h40, 8'h0f, 8'h1f, 8'h40, 8'hef, 8'h00};
    logic [7:0]            sw [4] = '{8'h09, 8'h01, 8'h0a, 8'h02};

    dcc_top dcc_top_i (.core_clk(core_clk), .reset(reset), .clk_en(1'b1), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cmp_raw(cmp_raw),
        .port_pin_in(port_pin_in), .sleep_active(sleep_active), .port_pin_out(port_pin_out),
        .port_pin_oe(port_pin_oe), .analog_ctl(analog_ctl), .ladder_ctl(ladder_ctl), .irq_req(irq_req),
        .wake_req(wake_req));

    // Compare and count
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // One bus cycle, held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge core_clk);
        avs_address <= {idx, 2'h0};
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h0, wd};
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk($sformatf("reg %h", idx), rd, exp);
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        end_sim();
    end
    // Test sequence
    initial begin
        {reset, avs_read, avs_write, sleep_active} = 4'h8;
        {avs_address, avs_writedata, cmp_raw, n_fail, n_tests} = '0;
        port_pin_in = 5'h1f;
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        foreach (regs[i]) rc(regs[i], rv[i]);
        rc(DCC_IDX_PORT_A_DATA, 8'h10);
        $display("test reset values done");
        foreach (regs[i]) begin
            bus(1'b1, regs[i], 8'hff);
            rc(regs[i], wv[i]);
        end
        chk("ladder", ladder_ctl, 8'hef);
        chk("soft irq", {6'h0, irq_req, analog_ctl.cmp_power}, 8'h02);
        foreach (regs[i]) bus(1'b1, regs[i], 8'h00);
        $display("test access kinds done");
        bus(1'b1, CTL, 8'h02);
        @(negedge core_clk);
        chk("intref", {6'h0, analog_ctl.cmp_power, analog_ctl.intref_to_noninv}, 8'h03);
        @(posedge core_clk) cmp_raw <= 2'b01;
        repeat (6) @(negedge core_clk);
        rc(FLG, 8'h40);
        bus(1'b1, FLG, 8'h00);
        rc(FLG, 8'h40);
        rc(CTL, 8'h42);
        bus(1'b1, FLG, 8'h00);
        rc(FLG, 8'h00);
        $display("test change flag done");
        bus(1'b1, DCC_IDX_PERIPHERAL_IRQ_ENABLES, 8'h40);
        bus(1'b1, DCC_IDX_INTERRUPT_CONTROL, 8'hc0);
        @(posedge core_clk) sleep_active <= 1'b1;
        @(posedge core_clk) cmp_raw <= 2'b11;
        repeat (6) @(negedge core_clk);
        chk("irq wake", {6'h0, irq_req, wake_req}, 8'h03);
        bus(1'b1, DCC_IDX_INTERRUPT_CONTROL, 8'h40);
        repeat (2) @(negedge core_clk);
        chk("irq gated", {7'h0, irq_req}, 8'h00);
        rc(FLG, 8'h40);
        @(posedge core_clk) sleep_active <= 1'b0;
        rc(CTL, 8'hc2);
        $display("test interrupt done");
        bus(1'b1, CTL, 8'h06);
        bus(1'b1, DIR, 8'h00);
        rc(DCC_IDX_PORT_A_DATA, 8'h18);
        @(posedge core_clk) cmp_raw <= 2'b01;
        repeat (3) @(negedge core_clk);
        chk("pin out", {3'h0, port_pin_out}, 8'h08);
        chk("pin oe", {6'h0, port_pin_oe[4:3]}, 8'h03);
        bus(1'b1, DIR, 8'h18);
        repeat (2) @(negedge core_clk);
        chk("pin oe off", {6'h0, port_pin_oe[4:3]}, 8'h00);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, CTL, sw[i]);
            repeat (2) @(negedge core_clk);
            chk("one src", {6'h0, analog_ctl.one_inv_src}, {7'h0, sw[i][3]});
            if (i > 1) chk("two src", {6'h0, analog_ctl.two_inv_src}, sw[i][3] ? 8'h02 : 8'h03);
        end
        $display("test routing done");
        @(posedge core_clk) cmp_raw <= 2'b00;
        @(posedge core_clk) reset <= 1'b1;
        repeat (2) @(negedge core_clk);
        chk("power", {7'h0, analog_ctl.cmp_power}, 8'h00);
        @(posedge core_clk) reset <= 1'b0;
        rc(CTL, 8'h00);
        $display("test second reset done");
        end_sim();
    end
endmodule // testbench
